// *** logic/tcm_defines.svh ***
// register map, field positions, reset values and timing figures of the channel pair block
`ifndef TCM_DEFINES_SVH
`define TCM_DEFINES_SVH

`define TCM_OFS_MODE 16'hE018
`define TCM_OFS_CMP_A 16'hE034
`define TCM_OFS_CMP_B 16'hE038
`define TCM_OFS_STATUS 16'hE03C

`define TCM_MODE_RESET 32'h0000_0000
`define TCM_MODE_USED_W 16
`define TCM_CH_STRIDE 8
`define TCM_DIR_LSB 0
`define TCM_FAST_BIT 2
`define TCM_PRELOAD_BIT 3
`define TCM_CMODE_LSB 4
`define TCM_PSC_LSB 2
`define TCM_FILT_LSB 4

`define TCM_CNT_W 16
`define TCM_CMP_RESET 16'h0000
`define TCM_DIV_W 5
`define TCM_FILT_CNT_W 4

`define TCM_CLK_NS 25
`define TCM_FAST_DELAY_CYC 3
`define TCM_SLOW_DELAY_CYC 5

`endif

// *** logic/tcm_pkg.sv ***
// types shared by the channel pair block
package tcm_pkg;

  typedef enum logic [2:0] {
    TCM_CM_FROZEN = 3'h0,
    TCM_CM_SET = 3'h1,
    TCM_CM_CLEAR = 3'h2,
    TCM_CM_TOGGLE = 3'h3,
    TCM_CM_FORCE_LO = 3'h4,
    TCM_CM_FORCE_HI = 3'h5,
    TCM_CM_PWM1 = 3'h6,
    TCM_CM_PWM2 = 3'h7
  } tcm_cmp_mode_t;

  typedef enum logic [1:0] {
    TCM_DIR_OUTPUT = 2'h0,
    TCM_DIR_OWN_PIN = 2'h1,
    TCM_DIR_OTHER_PIN = 2'h2,
    TCM_DIR_TRIGGER = 2'h3
  } tcm_dir_t;

endpackage : tcm_pkg

// *** logic/tcm_filt_if.sv ***
// link between a channel and its input filter
`timescale 1ns/10ps
interface tcm_filt_if;
  logic [3:0] code;
  logic raw;
  logic filt;
  logic rise;
  modport filter (input code, input raw, output filt, output rise);
  modport user (output code, output raw, input filt, input rise);
endinterface : tcm_filt_if

// *** logic/tcm_in_filter.sv ***
// sampled digital filter and rising edge detector for one capture input
`timescale 1ns/10ps
`include "tcm_defines.svh"
module tcm_in_filter
  import tcm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  tcm_filt_if.filter fif
);

  logic [`TCM_DIV_W-1:0] div_q;
  logic [`TCM_FILT_CNT_W-1:0] run_q;
  logic filt_q;
  logic filt_dly_q;
  logic [2:0] div_log2;
  logic [3:0] need_n;
  logic [`TCM_DIV_W-1:0] mask;
  logic sample_en;

  // code to {log2 divider, samples needed}
  function automatic logic [6:0] filt_decode(input logic [3:0] code);
    case (code)
      4'h0: filt_decode = {3'h0, 4'h1};
      4'h1: filt_decode = {3'h0, 4'h2};
      4'h2: filt_decode = {3'h0, 4'h4};
      4'h3: filt_decode = {3'h0, 4'h8};
      4'h4: filt_decode = {3'h1, 4'h6};
      4'h5: filt_decode = {3'h1, 4'h8};
      4'h6: filt_decode = {3'h2, 4'h6};
      4'h7: filt_decode = {3'h2, 4'h8};
      4'h8: filt_decode = {3'h3, 4'h6};
      4'h9: filt_decode = {3'h3, 4'h8};
      4'hA: filt_decode = {3'h4, 4'h5};
      4'hB: filt_decode = {3'h4, 4'h6};
      4'hC: filt_decode = {3'h4, 4'h8};
      4'hD: filt_decode = {3'h5, 4'h5};
      4'hE: filt_decode = {3'h5, 4'h6};
      default: filt_decode = {3'h5, 4'h8};
    endcase
  endfunction : filt_decode

  assign {div_log2, need_n} = filt_decode(fif.code);
  assign mask = 5'(~(32'hFFFF_FFFF << div_log2));
  assign sample_en = ((div_q & mask) == mask);

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_q <= '0;
    else
      div_q <= div_q + 5'h01;
  end

  // a run of differing samples resets as soon as one agrees again
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_q <= '0;
      filt_q <= 1'b0;
    end
    else if (sample_en)
    begin
      if (fif.raw == filt_q)
        run_q <= '0;
      else if ((run_q + 4'h1) >= need_n)
      begin
        filt_q <= fif.raw;
        run_q <= '0;
      end
      else
        run_q <= run_q + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      filt_dly_q <= 1'b0;
    else
      filt_dly_q <= filt_q;
  end

  assign fif.filt = filt_q;
  assign fif.rise = filt_q & ~filt_dly_q;

endmodule : tcm_in_filter

// *** logic/tcm_top.sv ***
// channel pair capture/compare block with mode register on apb
//
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
`include "tcm_defines.svh"
module tcm_top
  import tcm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`TCM_CNT_W-1:0] counter_value,
  input wire logic count_down,
  input wire logic update_event,
  input wire logic input_pin_a,
  input wire logic input_pin_b,
  input wire logic slave_trigger_input,
  output logic chan_a_reference_wave,
  output logic chan_b_reference_wave,
  output logic chan_a_capture,
  output logic chan_b_capture
);

  logic [`TCM_MODE_USED_W-1:0] mode_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic pin_a_q;
  logic pin_b_q;
  logic trig_q;
  logic trig_dly_q;
  logic trig_rise;
  logic setup;
  logic wr_en;
  logic [1:0] wr_cmp;
  logic [1:0][`TCM_CNT_W-1:0] cmp_rd;
  logic [1:0] ref_w;
  logic [1:0] cap_w;
  logic [1:0] filt_w;
  logic [3:0] reg_hit;

  // selected raw source for a channel input
  function automatic logic src_pick(input logic [1:0] dir, input logic own,
                                    input logic other, input logic trig);
    case (dir)
      TCM_DIR_OWN_PIN: src_pick = own;
      TCM_DIR_OTHER_PIN: src_pick = other;
      TCM_DIR_TRIGGER: src_pick = trig;
      default: src_pick = 1'b0;
    endcase
  endfunction : src_pick

  // events needed per capture
  function automatic logic [2:0] psc_count(input logic [1:0] psc);
    case (psc)
      2'h0: psc_count = 3'h1;
      2'h1: psc_count = 3'h2;
      2'h2: psc_count = 3'h4;
      default: psc_count = 3'h6;
    endcase
  endfunction : psc_count

  // one-hot register select shared by read and write paths
  function automatic logic [3:0] reg_sel(input logic [15:0] a);
    reg_sel = 4'h0;
    if (a == `TCM_OFS_MODE)
      reg_sel = 4'h1;
    else if (a == `TCM_OFS_CMP_A)
      reg_sel = 4'h2;
    else if (a == `TCM_OFS_CMP_B)
      reg_sel = 4'h4;
    else if (a == `TCM_OFS_STATUS)
      reg_sel = 4'h8;
  endfunction : reg_sel

  ////////////////////////////////////////////////////////////////////////
  // apb slave: answer ready in the first access cycle

  assign setup = psel & ~penable;
  assign reg_hit = reg_sel(paddr);
  assign wr_en = psel & penable & pwrite & pready_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end
    else
    begin
      pready_q <= setup;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
      if (setup)
      begin
        if (reg_hit[0])
          prdata_q <= {16'h0000, mode_q};
        else if (reg_hit[1])
          prdata_q <= {16'h0000, cmp_rd[0]};
        else if (reg_hit[2])
          prdata_q <= {16'h0000, cmp_rd[1]};
        else if (reg_hit[3])
          prdata_q <= {26'h0, cap_w, filt_w, ref_w};
        else
          pslverr_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_q <= 16'(`TCM_MODE_RESET);
    else if (wr_en && reg_hit[0])
      mode_q <= pwdata[`TCM_MODE_USED_W-1:0];
  end

  assign wr_cmp[0] = wr_en && reg_hit[1];
  assign wr_cmp[1] = wr_en && reg_hit[2];

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  ////////////////////////////////////////////////////////////////////////
  // input sampling; pins are synchronous so one stage suffices

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_a_q <= 1'b0;
      pin_b_q <= 1'b0;
      trig_q <= 1'b0;
      trig_dly_q <= 1'b0;
    end
    else
    begin
      pin_a_q <= input_pin_a;
      pin_b_q <= input_pin_b;
      trig_q <= slave_trigger_input;
      trig_dly_q <= trig_q;
    end
  end

  assign trig_rise = trig_q & ~trig_dly_q;

  ////////////////////////////////////////////////////////////////////////
  // the two channels

  for (genvar ch = 0; ch < 2; ch++)
  begin : g_ch
    localparam int B = ch * `TCM_CH_STRIDE;
    tcm_filt_if fif ();
    logic [1:0] dir;
    tcm_cmp_mode_t cmode;
    logic preload;
    logic fast;
    logic [1:0] psc;
    logic is_out;
    logic own_pin;
    logic other_pin;
    logic match;
    logic cmp_lt;
    logic cmp_gt;
    logic pwm_lvl;
    logic is_pwm;
    logic fast_set;
    logic cap_now;
    logic [`TCM_CNT_W-1:0] buf_q;
    logic [`TCM_CNT_W-1:0] shadow_q;
    logic [2:0] evt_q;
    logic ref_q;
    logic ref_d;
    logic cap_q;
    logic pwm_prev_q;
    logic fast_q;

    assign dir = mode_q[B+`TCM_DIR_LSB +: 2];
    assign cmode = tcm_cmp_mode_t'(mode_q[B+`TCM_CMODE_LSB +: 3]);
    assign preload = mode_q[B+`TCM_PRELOAD_BIT];
    assign fast = mode_q[B+`TCM_FAST_BIT];
    assign psc = mode_q[B+`TCM_PSC_LSB +: 2];
    assign is_out = (dir == TCM_DIR_OUTPUT);

    // channel A's other pin is B and vice versa
    assign own_pin = (ch == 0) ? pin_a_q : pin_b_q;
    assign other_pin = (ch == 0) ? pin_b_q : pin_a_q;
    assign fif.raw = src_pick(dir, own_pin, other_pin, trig_q);
    assign fif.code = is_out ? 4'h0 : mode_q[B+`TCM_FILT_LSB +: 4];

    tcm_in_filter u_filt (
      .pclk(pclk),
      .presetn(presetn),
      .fif(fif)
    );

    // prescaler counts filtered rising edges
    assign cap_now = !is_out && fif.rise && ((evt_q + 3'h1) >= psc_count(psc));

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        evt_q <= '0;
      else if (is_out)
        evt_q <= '0;
      else if (fif.rise)
        evt_q <= cap_now ? 3'h0 : evt_q + 3'h1;
    end

    // capture overrides a write landing in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        buf_q <= `TCM_CMP_RESET;
        shadow_q <= `TCM_CMP_RESET;
      end
      else if (cap_now)
      begin
        buf_q <= counter_value;
        shadow_q <= counter_value;
      end
      else
      begin
        if (wr_cmp[ch])
          buf_q <= pwdata[`TCM_CNT_W-1:0];
        if (wr_cmp[ch] && !(preload && is_out))
          shadow_q <= pwdata[`TCM_CNT_W-1:0];
        else if (update_event && preload && is_out)
          shadow_q <= buf_q;
      end
    end

    assign cmp_rd[ch] = (preload && is_out) ? buf_q : shadow_q;

    // comparison against the active shadow value
    assign match = (counter_value == shadow_q);
    assign cmp_lt = (counter_value < shadow_q);
    assign cmp_gt = (counter_value > shadow_q);
    assign is_pwm = (cmode == TCM_CM_PWM1) || (cmode == TCM_CM_PWM2);

    always_comb
    begin
      if (cmode == TCM_CM_PWM1)
        pwm_lvl = count_down ? !cmp_gt : cmp_lt;
      else
        pwm_lvl = count_down ? cmp_gt : !cmp_lt;
    end

    // fast path: a trigger edge acts as a match, held until the comparison moves
    assign fast_set = is_out && is_pwm && fast && trig_rise;

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        fast_q <= 1'b0;
        pwm_prev_q <= 1'b0;
      end
      else
      begin
        pwm_prev_q <= pwm_lvl;
        if (fast_set)
          fast_q <= 1'b1;
        else if (!is_pwm || !is_out || (pwm_lvl != pwm_prev_q))
          fast_q <= 1'b0;
      end
    end

    always_comb
    begin
      ref_d = ref_q;
      if (is_out)
      begin
        case (cmode)
          TCM_CM_FROZEN: ref_d = ref_q;
          TCM_CM_SET: ref_d = match ? 1'b1 : ref_q;
          TCM_CM_CLEAR: ref_d = match ? 1'b0 : ref_q;
          TCM_CM_TOGGLE: ref_d = match ? ~ref_q : ref_q;
          TCM_CM_FORCE_LO: ref_d = 1'b0;
          TCM_CM_FORCE_HI: ref_d = 1'b1;
          default: ref_d = pwm_lvl | fast_q | fast_set;
        endcase
      end
    end

    // toggle re-fires every cycle the counter sits on the compare value
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        ref_q <= 1'b0;
        cap_q <= 1'b0;
      end
      else
      begin
        ref_q <= ref_d;
        cap_q <= cap_now;
      end
    end

    assign ref_w[ch] = ref_q;
    assign cap_w[ch] = cap_q;
    assign filt_w[ch] = fif.filt;
  end

  assign chan_a_reference_wave = g_ch[0].ref_q;
  assign chan_b_reference_wave = g_ch[1].ref_q;
  assign chan_a_capture = g_ch[0].cap_q;
  assign chan_b_capture = g_ch[1].cap_q;

endmodule : tcm_top

// *** sim/tcm_top_asserts.sv ***
// port assertions for the channel pair block
`timescale 1ns/10ps
`include "tcm_defines.svh"
module tcm_top_asserts
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic slave_trigger_input,
  input wire logic chan_a_reference_wave,
  input wire logic chan_a_capture
);
  logic [15:0] mode_q;
  logic acc;
  logic out_a;
  logic ref_a;
  assign acc = psel && penable && pready;
  assign out_a = mode_q[1:0] == 2'h0;
  assign ref_a = chan_a_reference_wave;
  ////////////////////////////////////////////////////////////////////////////////
  // shadow of the mode word, stored at the same edge as the device's copy
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_q <= 16'h0000;
    else if (acc && pwrite && paddr == `TCM_OFS_MODE)
      mode_q <= pwdata[15:0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  ready_after_setup_a:
    assert property (psel && !penable |=> pready) else $error("pready missing");
  ready_single_a:
    assert property (pready |=> !pready) else $error("pready held");
  unmapped_error_a:
    assert property (acc && !(paddr inside {16'hE018, 16'hE034, 16'hE038, 16'hE03C})
      |-> pslverr) else $error("no slave error");
  upper_zero_a:
    assert property (acc && !pwrite && paddr == `TCM_OFS_MODE |-> prdata[31:16] == 16'h0000)
      else $error("upper mode bits set");
  force_low_a:
    assert property (out_a && mode_q[6:4] == 3'h4 && $past(mode_q) == mode_q |-> !ref_a)
      else $error("forced low not low");
  force_high_a:
    assert property (out_a && mode_q[6:4] == 3'h5 && $past(mode_q) == mode_q |-> ref_a)
      else $error("forced high not high");
  frozen_hold_a:
    assert property (out_a && mode_q[6:4] == 3'h0 && $past(mode_q) == mode_q
      |-> $stable(ref_a)) else $error("frozen reference moved");
  input_hold_a:
    assert property (!out_a && $past(mode_q) == mode_q |-> $stable(ref_a))
      else $error("input channel reference moved");
  fast_trigger_a:
    assert property (out_a && mode_q[6:5] == 2'b11 && mode_q[2] && $rose(slave_trigger_input)
      |-> ##[1:3] ref_a) else $error("fast trigger late");
  capture_input_a:
    assert property (chan_a_capture |-> !out_a ##1 !chan_a_capture)
      else $error("capture on output channel");
endmodule : tcm_top_asserts

bind tcm_top tcm_top_asserts i_tcm_top_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .slave_trigger_input(slave_trigger_input),
  .chan_a_reference_wave(chan_a_reference_wave), .chan_a_capture(chan_a_capture));

// *** sim/tcm_pins_model.sv ***
// timer counter model feeding the channel pair block
`timescale 1ns/10ps
module tcm_pins_model
#(
  parameter int PERIOD = 64
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic down,
  output logic [15:0] counter_value,
  output logic count_down,
  output logic update_event
);
  logic wrap;
  assign count_down = down;
  assign wrap = counter_value == (down ? 16'h0000 : 16'(PERIOD - 1));
  // update pulse only at a wrap, so preload tests see one per period
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      counter_value <= 16'h0000;
      update_event <= 1'b0;
    end
    else
    begin
      update_event <= run && wrap;
      if (run)
        counter_value <= wrap ? (down ? 16'(PERIOD - 1) : 16'h0000)
          : (down ? counter_value - 16'h0001 : counter_value + 16'h0001);
    end
  end
endmodule : tcm_pins_model

// *** sim/timer_channel_mode_config_bench.sv ***
// apb sequences checking the channel pair block
`timescale 1ns/10ps
module timer_channel_mode_config_bench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic pready, pslverr, err, ref_a, ref_b, cap_a, cap_b, run = 1'b0, down = 1'b0;
  logic [2:0] pins = 3'h0;
  logic [15:0] counter_value;
  logic count_down, update_event;
  int bad_count, comparisons, ncap[2], x, k;
  tcm_top i_tcm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .counter_value(counter_value), .count_down(count_down),
    .update_event(update_event), .input_pin_a(pins[0]), .input_pin_b(pins[1]),
    .slave_trigger_input(pins[2]), .chan_a_reference_wave(ref_a),
    .chan_b_reference_wave(ref_b), .chan_a_capture(cap_a), .chan_b_capture(cap_b));
  tcm_pins_model #(.PERIOD(64)) i_tcm_pins_model (.pclk(pclk), .presetn(presetn), .run(run),
    .down(down), .counter_value(counter_value), .count_down(count_down),
    .update_event(update_event));
  initial forever #12.5 pclk = ~pclk;
  always @(posedge pclk)
  begin
    ncap[0] += cap_a;
    ncap[1] += cap_b;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (e !== g)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1 && ++n < 20);
    chk("pready", 1, pready);
    rd_q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input string s, input logic [15:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(s, e, rd_q);
  endtask : rd
  // returns one edge after the counter shows v
  task automatic at_count(input int v);
    int n;
    n = 0;
    do
      @(posedge pclk);
    while (counter_value !== 16'(v) && ++n < 300);
    @(posedge pclk);
    #1;
  endtask : at_count
  task automatic pulse(input int p, input int len);
    @(posedge pclk);
    pins[p] <= 1'b1;
    repeat (len) @(posedge pclk);
    pins[p] <= 1'b0;
    repeat (len + 40) @(posedge pclk);
  endtask : pulse
  // two counter periods, so exactly two matches
  task automatic changes(output int c);
    logic last;
    c = 0;
    last = ref_a;
    repeat (128)
    begin
      @(posedge pclk);
      c += (ref_a !== last);
      last = ref_a;
    end
  endtask : changes
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd("mode reset", 16'hE018, 32'h0);
    rd("cmp reset", 16'hE034, 32'h0);
    wr(16'hE018, 32'hFFFF_FFFF);
    rd("mode upper", 16'hE018, 32'h0000_FFFF);
    apb(1'b0, 16'hE040, 32'h0);
    chk("slverr", 1, err);
    for (k = 0; k < 2; k++)
    begin
      wr(16'hE018, k ? 32'h5040 : 32'h4050);
      repeat (3) @(posedge pclk);
      chk("ref a force", !k, ref_a);
      chk("ref b force", k, ref_b);
    end
    rd("status", 16'hE03C, 32'h0000_0002);
    wr(16'hE034, 32'h0010);
    run <= 1'b1;
    for (k = 1; k <= 3; k++)
    begin
      wr(16'hE018, 32'(k << 4));
      at_count(16);
      chk("match ref", k != 2, ref_a);
    end
    changes(x);
    chk("toggles", 2, x);
    wr(16'hE018, 32'h0);
    changes(x);
    chk("frozen", 0, x);
    wr(16'hE034, 32'h0020);
    for (k = 0; k < 8; k++)
    begin
      down <= k[1];
      wr(16'hE018, k[2] ? 32'h78 : 32'h68);
      x = k[1] ? 33 + k[0] : 30 + k[0];
      at_count(x);
      // reference shows the count one edge past x
      x = k[1] ? x - 1 : x + 1;
      chk("pwm ref", k[2] ^ (k[1] ? x <= 32 : x < 32), ref_a);
    end
    down <= 1'b0;
    wr(16'hE034, 32'h0030);
    rd("buffer", 16'hE034, 32'h0030);
    repeat (70) @(posedge pclk);
    at_count(40);
    chk("shadow loaded", 0, ref_a);
    at_count(53);
    run <= 1'b0;
    for (k = 0; k < 2; k++)
    begin
      wr(16'hE018, k ? 32'h6C : 32'h68);
      @(posedge pclk);
      pins[2] <= 1'b1;
      repeat (3) @(posedge pclk);
      #1;
      chk("fast ref", k, ref_a);
      pins[2] <= 1'b0;
    end
    for (k = 0; k < 6; k++)
    begin
      wr(16'hE018, 32'h0);
      wr(16'hE018, 32'((k % 3 + 1) << (k / 3 * 8)));
      run <= 1'b1;
      repeat (k + 3) @(posedge pclk);
      run <= 1'b0;
      x = ncap[k / 3];
      pulse(k % 3 == 2 ? 2 : (k % 3) ^ (k / 3), 4);
      chk("capture count", x + 1, ncap[k / 3]);
      rd("captured", 16'hE034 + 16'(k / 3 * 4), 32'(counter_value));
    end
    for (k = 0; k < 4; k++)
    begin
      wr(16'hE018, 32'h1 | (k << 2));
      x = ncap[0];
      repeat (k ? 2 * k : 1) pulse(0, 4);
      chk("prescale", x + 1, ncap[0]);
    end
    for (k = 0; k < 4; k++)
    begin
      wr(16'hE018, k[1] ? 32'hF1 : 32'h31);
      x = ncap[0];
      pulse(0, k[1] ? (k[0] ? 320 : 200) : (k[0] ? 12 : 3));
      chk("filter", x + k[0], ncap[0]);
    end
    complete_run();
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    complete_run();
  end
endmodule : timer_channel_mode_config_bench
